// ===== uart_pin_routing_irq_out_test.sv
`timescale 1ns/1ps

module uart_pin_routing_irq_out_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, r;
   logic pready, pslverr, e, rx_pin_out, rx_pin_oe, tx_pin;
   logic irq_out_o, irq_out_oe, offhook_relay_out, uart_rx_data, irq;
   logic sp, rs, rxl, ui, mi, mrx, utx, rx_wire;
   logic path, leg, tz, oh, xo, xt, xi;
   logic [6:0] want = 7'h23;
   int err_total = 0, n_checks = 0, cyc = 0, i;
   logic [31:0] seed = 32'h0001_13a8;
   initial forever #50 pclk = ~pclk;
   // Receive wire: the device wins while it drives
   assign rx_wire = rx_pin_oe ? rx_pin_out : rxl;
   upr_far_model far_u (.pclk(pclk), .presetn(presetn), .want(want),
      .single_port_select(sp), .host_read_strobe_n(rs), .rx_level(rxl),
      .uart_irq(ui), .modem_detect_irq(mi), .modem_rx_data(mrx),
      .uart_tx_data(utx));
   upr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .single_port_select(sp), .host_read_strobe_n(rs),
      .rx_pin_in(rx_wire), .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe),
      .tx_pin(tx_pin), .irq_out_o(irq_out_o), .irq_out_oe(irq_out_oe),
      .offhook_relay_out(offhook_relay_out), .uart_irq(ui),
      .modem_detect_irq(mi), .modem_rx_data(mrx), .uart_tx_data(utx),
      .uart_rx_data(uart_rx_data), .irq(irq));
   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic settle(input logic [6:0] v);
      @(posedge pclk);
      want <= v;
      repeat (8) @(posedge pclk);
      #1;
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         report_and_stop();
      end
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      #1 check("offhook reset", offhook_relay_out, 1'b1);
      check("tx reset", tx_pin, upr_pkg::MARK_LEVEL);
      apb(0, upr_pkg::ADDR_CTRL, 32'h0);
      check("ctrl reset", rd, 32'h0);
      apb(0, upr_pkg::ADDR_IRQ_MASK, 32'h0);
      check("mask reset", rd, 32'h0);
      for (i = 0; i < 48; i++)
      begin
         seed = xs(seed);
         r = seed;
         {oh, path, tz, leg} = r[3:0];
         apb(1, upr_pkg::ADDR_CTRL, {28'h0, oh, path, tz, leg});
         settle(r[10:4]);
         xo = !sp && !path;
         xt = (path || !sp) ? utx : 1'b1;
         xi = (ui | (sp & mi)) & (leg | rs);
         check("rx oe", rx_pin_oe, xo);
         if (xo)
            check("rx out", rx_pin_out, mrx);
         check("uart rx", uart_rx_data, path ? rxl : 1'b1);
         check("tx", tx_pin, xt);
         check("irq oe", irq_out_oe, tz);
         check("irq lvl", irq_out_o, xi);
         check("offhook", offhook_relay_out, !oh);
         check("irq masked", irq, 1'b0);
         apb(0, upr_pkg::ADDR_CTRL, 32'h0);
         check("ctrl rb", rd, {28'h0, oh, path, tz, leg});
         check("rd err", e, 1'b0);
         apb(0, upr_pkg::ADDR_STATUS, 32'h0);
         check("status", rd[4:0], {xt, xo, tz, xi, sp});
      end
      settle(7'h23);
      apb(1, upr_pkg::ADDR_IRQ_STATUS, 32'h3);
      apb(0, upr_pkg::ADDR_IRQ_STATUS, 32'h0);
      check("sts clear", rd, 32'h0);
      apb(1, upr_pkg::ADDR_IRQ_MASK, 32'h1);
      settle(7'h2b);
      apb(0, upr_pkg::ADDR_IRQ_STATUS, 32'h0);
      check("sts uart", rd, 32'h1);
      check("irq on", irq, 1'b1);
      apb(1, upr_pkg::ADDR_IRQ_MASK, 32'h2);
      #1 check("irq masked off", irq, 1'b0);
      settle(7'h2f);
      apb(0, upr_pkg::ADDR_IRQ_STATUS, 32'h0);
      check("sts both", rd, 32'h3);
      check("irq modem", irq, 1'b1);
      apb(1, upr_pkg::ADDR_IRQ_STATUS, 32'h3);
      apb(0, upr_pkg::ADDR_IRQ_STATUS, 32'h0);
      check("sts w1c", rd, 32'h0);
      check("irq cleared", irq, 1'b0);
      // Event lands on the same edge as the clear write
      settle(7'h23);
      fork
         apb(1, upr_pkg::ADDR_IRQ_STATUS, 32'h1);
         begin
            @(posedge pclk);
            want <= 7'h2b;
         end
      join
      apb(0, upr_pkg::ADDR_IRQ_STATUS, 32'h0);
      check("set wins", rd, 32'h1);
      // Reset in mid-run
      settle(7'h23);
      @(posedge pclk);
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      #1 check("offhook rst2", offhook_relay_out, 1'b1);
      check("irq oe rst2", irq_out_oe, 1'b0);
      check("tx rst2", tx_pin, upr_pkg::MARK_LEVEL);
      apb(0, upr_pkg::ADDR_IRQ_STATUS, 32'h0);
      check("sts rst2", rd, 32'h0);
      apb(0, upr_pkg::ADDR_CTRL, 32'h0);
      check("ctrl rst2", rd, 32'h0);
      apb(1, 8'h10, 32'hffff_ffff);
      check("bad wr err", e, 1'b1);
      apb(0, 8'h10, 32'h0);
      check("bad rd err", e, 1'b1);
      check("bad rd data", rd, 32'h0);
      report_and_stop();
   end
endmodule

// ===== upr_far_model.sv
`timescale 1ns/1ps

module upr_far_model
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Levels requested by the bench
   input wire logic [6:0] want,
   // Pins and internal sources
   output logic single_port_select,
   output logic host_read_strobe_n,
   output logic rx_level,
   output logic uart_irq,
   output logic modem_detect_irq,
   output logic modem_rx_data,
   output logic uart_tx_data
);
   // ****************************************************************
   // Far side levels, updated after each rising edge
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {single_port_select, host_read_strobe_n, rx_level} <= 3'h2;
         {uart_irq, modem_detect_irq} <= 2'h0;
         {modem_rx_data, uart_tx_data} <= 2'h3;
      end
      else
      begin
         {single_port_select, host_read_strobe_n, rx_level} <= want[6:4];
         {uart_irq, modem_detect_irq} <= want[3:2];
         {modem_rx_data, uart_tx_data} <= want[1:0];
      end
   end
endmodule

// ===== upr_pkg.sv
package upr_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int CTRL_LEGACY_SEL = 0;
   localparam int CTRL_TRISTATE = 1;
   localparam int CTRL_PATH_SEL = 2;
   localparam int CTRL_OFFHOOK = 3;
   localparam int CTRL_WIDTH = 4;
   localparam logic [3:0] CTRL_RESET = 4'h0;

   // ****************************************************************
   // Interrupt status fields
   // ****************************************************************
   localparam int IRQ_UART = 0;
   localparam int IRQ_MODEM = 1;
   localparam int IRQ_WIDTH = 2;
   localparam logic [1:0] IRQ_RESET = 2'h0;

   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
   localparam logic MARK_LEVEL = 1'b1;

   typedef struct packed
   {
      logic offhook;
      logic path_sel;
      logic tristate;
      logic legacy_sel;
   } upr_ctrl_type;

   typedef struct packed
   {
      logic out;
      logic oe;
   } upr_pin_type;

   typedef enum logic [1:0]
   {
      ROUTE_MODEM_RX,
      ROUTE_IGNORE_RX,
      ROUTE_UART_RX
   } upr_route_type;

endpackage

// ===== upr_route.sv
`timescale 1ns/1ps

module upr_route
(
   // Selection
   input wire logic single_port_select,
   input wire logic uart_path_select,
   // Serial streams
   input wire logic modem_rx_data,
   input wire logic uart_tx_data,
   // Results
   output upr_pkg::upr_route_type route,
   output upr_pkg::upr_pin_type rx_pin,
   output logic tx_level
);

   always_comb
   begin
      if (uart_path_select)
      begin
         route = upr_pkg::ROUTE_UART_RX;
      end
      else if (single_port_select)
      begin
         route = upr_pkg::ROUTE_IGNORE_RX;
      end
      else
      begin
         route = upr_pkg::ROUTE_MODEM_RX;
      end
   end

   always_comb
   begin
      rx_pin.oe = 1'b0;
      rx_pin.out = 1'b0;
      tx_level = uart_tx_data;
      case (route)
         upr_pkg::ROUTE_MODEM_RX:
         begin
            rx_pin.oe = 1'b1;
            rx_pin.out = modem_rx_data;
         end
         upr_pkg::ROUTE_IGNORE_RX:
         begin
            tx_level = upr_pkg::MARK_LEVEL;
         end
         default:
         begin
            rx_pin.oe = 1'b0;
         end
      endcase
   end

endmodule

// ===== upr_top.sv
// How it works
// - The interrupt output goes active when any enabled UART interrupt occurs.
// - With the legacy select bit at 0 the interrupt is gated by read strobe.
// - With the tristate control bit at 0 the interrupt output is released to high-Z.
// - In single-port mode a modem detect interrupt also drives the output.
// - Single-port low, path bit clear: receive pin drives modem rx data.
// - Single-port high, path bit clear: receive pin is input and ignored.
// - Path bit set: receive pin feeds the UART receiver.
// - Path bit set, or single-port low: transmit pin carries UART data.
// - Single-port high, path bit clear: transmit pin is held at mark.
// - The off-hook relay output is the inverse of the off-hook bit.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps

module upr_top
(
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic single_port_select,
   input wire logic host_read_strobe_n,
   input wire logic rx_pin_in,
   output logic rx_pin_out,
   output logic rx_pin_oe,
   output logic tx_pin,
   output logic irq_out_o,
   output logic irq_out_oe,
   output logic offhook_relay_out,
   // Internal UART and modem
   input wire logic uart_irq,
   input wire logic modem_detect_irq,
   input wire logic modem_rx_data,
   input wire logic uart_tx_data,
   output logic uart_rx_data,
   output logic irq
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic sps;
   logic strobe_n;
   logic rx_in;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_a <= 3'h7;
         sync_b <= 3'h7;
      end
      else
      begin
         sync_a <= {single_port_select, host_read_strobe_n, rx_pin_in};
         sync_b <= sync_a;
      end
   end

   assign sps = sync_b[2];
   assign strobe_n = sync_b[1];
   assign rx_in = sync_b[0];

   // ****************************************************************
   // Registers
   // ****************************************************************
   upr_pkg::upr_ctrl_type ctrl;
   logic [upr_pkg::IRQ_WIDTH-1:0] irq_status;
   logic [upr_pkg::IRQ_WIDTH-1:0] irq_mask;
   logic [upr_pkg::IRQ_WIDTH-1:0] irq_event;
   logic [upr_pkg::IRQ_WIDTH-1:0] irq_clear;
   logic wr_en;
   logic uart_d;
   logic modem_d;

   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;

   function automatic logic addr_known(input logic [7:0] a);
      return a == upr_pkg::ADDR_CTRL || a == upr_pkg::ADDR_STATUS ||
         a == upr_pkg::ADDR_IRQ_STATUS || a == upr_pkg::ADDR_IRQ_MASK;
   endfunction

   assign pslverr = psel && penable && !addr_known(paddr);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= upr_pkg::CTRL_RESET;
      end
      else if (wr_en && paddr == upr_pkg::ADDR_CTRL)
      begin
         ctrl <= pwdata[upr_pkg::CTRL_WIDTH-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_mask <= upr_pkg::IRQ_RESET;
      end
      else if (wr_en && paddr == upr_pkg::ADDR_IRQ_MASK)
      begin
         irq_mask <= pwdata[upr_pkg::IRQ_WIDTH-1:0];
      end
   end

   // Rising-edge events of the interrupt sources
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         uart_d <= 1'b0;
         modem_d <= 1'b0;
      end
      else
      begin
         uart_d <= uart_irq;
         modem_d <= modem_detect_irq;
      end
   end

   assign irq_event[upr_pkg::IRQ_UART] = uart_irq && !uart_d;
   assign irq_event[upr_pkg::IRQ_MODEM] = modem_detect_irq && !modem_d;
   assign irq_clear = (wr_en && paddr == upr_pkg::ADDR_IRQ_STATUS) ?
      pwdata[upr_pkg::IRQ_WIDTH-1:0] : upr_pkg::IRQ_RESET;

   // Set wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_status <= upr_pkg::IRQ_RESET;
      end
      else
      begin
         irq_status <= (irq_status & ~irq_clear) | irq_event;
      end
   end

   assign irq = |(irq_status & irq_mask);

   sequence s_uart_clear;
      irq_clear[upr_pkg::IRQ_UART] && !irq_event[upr_pkg::IRQ_UART];
   endsequence

   sequence s_modem_clear;
      irq_clear[upr_pkg::IRQ_MODEM] && !irq_event[upr_pkg::IRQ_MODEM];
   endsequence

   chk_sts_uart_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      irq_event[upr_pkg::IRQ_UART] |=> irq_status[upr_pkg::IRQ_UART])
      else $error("uart event not held in status");

   chk_sts_modem_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      irq_event[upr_pkg::IRQ_MODEM] |=> irq_status[upr_pkg::IRQ_MODEM])
      else $error("modem event not held in status");

   chk_sts_uart_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_uart_clear |=> !irq_status[upr_pkg::IRQ_UART])
      else $error("uart status not cleared");

   chk_sts_modem_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_modem_clear |=> !irq_status[upr_pkg::IRQ_MODEM])
      else $error("modem status not cleared");

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= upr_pkg::RDATA_ZERO;
      end
      else if (psel && !penable && !pwrite)
      begin
         prdata <= upr_pkg::RDATA_ZERO;
         case (paddr)
            upr_pkg::ADDR_CTRL:
               prdata[upr_pkg::CTRL_WIDTH-1:0] <= ctrl;
            upr_pkg::ADDR_STATUS:
            begin
               prdata[0] <= sps;
               prdata[1] <= irq_out_o;
               prdata[2] <= irq_out_oe;
               prdata[3] <= rx_pin_oe;
               prdata[4] <= tx_pin;
            end
            upr_pkg::ADDR_IRQ_STATUS:
               prdata[upr_pkg::IRQ_WIDTH-1:0] <= irq_status;
            upr_pkg::ADDR_IRQ_MASK:
               prdata[upr_pkg::IRQ_WIDTH-1:0] <= irq_mask;
            default:
               prdata <= upr_pkg::RDATA_ZERO;
         endcase
      end
   end

   chk_rd_unmapped_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && !addr_known(paddr)
      |=> prdata == upr_pkg::RDATA_ZERO)
      else $error("unmapped read not zero");

   // ****************************************************************
   // Serial pin routing
   // ****************************************************************
   upr_pkg::upr_route_type route;
   upr_pkg::upr_pin_type rx_pin;
   logic tx_level;

   upr_route u_route
   (
      .single_port_select(sps),
      .uart_path_select(ctrl.path_sel),
      .modem_rx_data(modem_rx_data),
      .uart_tx_data(uart_tx_data),
      .route(route),
      .rx_pin(rx_pin),
      .tx_level(tx_level)
   );

   // ****************************************************************
   // Pin output flops
   // ****************************************************************
   logic next_irq_level;

   // With legacy select at 0 the interrupt shows only while the read strobe is high
   always_comb
   begin
      next_irq_level = uart_irq || (sps && modem_detect_irq);
      if (!ctrl.legacy_sel && !strobe_n)
      begin
         next_irq_level = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_pin_out <= 1'b0;
         rx_pin_oe <= 1'b0;
         tx_pin <= upr_pkg::MARK_LEVEL;
         uart_rx_data <= upr_pkg::MARK_LEVEL;
         irq_out_o <= 1'b0;
         irq_out_oe <= 1'b0;
         offhook_relay_out <= 1'b1;
      end
      else
      begin
         rx_pin_out <= rx_pin.out;
         rx_pin_oe <= rx_pin.oe;
         tx_pin <= tx_level;
         uart_rx_data <= (route == upr_pkg::ROUTE_UART_RX) ? rx_in :
            upr_pkg::MARK_LEVEL;
         irq_out_o <= next_irq_level;
         irq_out_oe <= ctrl.tristate;
         offhook_relay_out <= !ctrl.offhook;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_single_idle;
      sps && !ctrl.path_sel;
   endsequence

   chk_irq_uart_drive: assert property (
      @(posedge pclk) disable iff (!presetn)
      uart_irq && !(!ctrl.legacy_sel && !strobe_n) |=> irq_out_o)
      else $error("irq not raised by uart source");

   chk_irq_legacy_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      !ctrl.legacy_sel && !strobe_n |=> !irq_out_o)
      else $error("legacy gating failed");

   chk_irq_tristate: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 irq_out_oe == $past(ctrl.tristate))
      else $error("irq enable not following control bit");

   chk_irq_modem_merge: assert property (
      @(posedge pclk) disable iff (!presetn)
      sps && modem_detect_irq && ctrl.legacy_sel |=> irq_out_o)
      else $error("modem irq not merged");

   chk_irq_idle_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      !uart_irq && !(sps && modem_detect_irq) |=> !irq_out_o)
      else $error("irq raised with no source");

   chk_rx_modem_out: assert property (
      @(posedge pclk) disable iff (!presetn)
      !sps && !ctrl.path_sel
      |=> rx_pin_oe && rx_pin_out == $past(modem_rx_data))
      else $error("rx pin not driving modem data");

   chk_rx_ignored: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_single_idle |=> !rx_pin_oe && uart_rx_data)
      else $error("rx pin not ignored");

   chk_rx_uart_in: assert property (
      @(posedge pclk) disable iff (!presetn)
      ctrl.path_sel |=> !rx_pin_oe && uart_rx_data == $past(rx_in))
      else $error("rx pin not feeding uart");

   chk_uart_rx_mark: assert property (
      @(posedge pclk) disable iff (!presetn)
      !ctrl.path_sel |=> uart_rx_data == upr_pkg::MARK_LEVEL)
      else $error("uart receiver not idle at mark");

   chk_tx_uart_data: assert property (
      @(posedge pclk) disable iff (!presetn)
      ctrl.path_sel || !sps |=> tx_pin == $past(uart_tx_data))
      else $error("tx pin not carrying uart data");

   chk_tx_mark_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_single_idle [*2] |=> tx_pin == upr_pkg::MARK_LEVEL)
      else $error("tx pin not at mark");

   chk_offhook_inverse: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 offhook_relay_out == !$past(ctrl.offhook))
      else $error("offhook relay not inverted");

endmodule
